// *** include/emcr_defs.svh ***
`ifndef EMCR_DEFS_SVH
`define EMCR_DEFS_SVH

// register indices (dword offsets); byte address is four times the index
`define EMCR_IDX_VERSION   4'h0
`define EMCR_IDX_SCRATCH   4'h1
`define EMCR_IDX_CONTROL   4'h2
`define EMCR_IDX_ADDR_LO   4'h3
`define EMCR_IDX_ADDR_HI   4'h4
`define EMCR_IDX_FRM_LEN   4'h5
`define EMCR_IDX_PAUSE     4'h6
`define EMCR_IDX_SECT_EMP  4'h7
`define EMCR_IDX_SECT_FUL  4'h8
`define EMCR_IDX_SOFT_RST  4'h9
`define EMCR_IDX_STATUS    4'ha
`define EMCR_IDX_LAST      4'ha
`define EMCR_IDX_NONE      4'hf

// field positions
`define EMCR_TRANSMIT_ENABLE_BIT_BIT    0
`define EMCR_RECEIVE_ENABLE_BIT_BIT    1
`define EMCR_PROMIS_BIT    4
`define EMCR_SRST_BIT      0

// reset and fixed values
`define EMCR_ZERO32        32'h0000_0000
`define EMCR_ZERO16        16'h0000
`define EMCR_FRM_LEN_RST   16'h05ee
`define EMCR_SECT_MARGIN   16'h0010
`define EMCR_CORE_VERSION  16'h0001
`define EMCR_CUST_REV      16'h0000
`define EMCR_FIFO_DEPTH    16'h0800

// ahb codes
`define EMCR_HTRANS_NONSEQ 2'b10
`define EMCR_HTRANS_SEQ    2'b11
`define EMCR_HSIZE_WORD    3'b010
`define EMCR_HRESP_OKAY    1'b0

`endif

// *** include/emcr_pkg.sv ***
package emcr_pkg;

   typedef struct packed {
      logic [31:0] addr;
      logic [1:0] trans;
      logic write;
      logic [2:0] size;
      logic sel;
   } emcr_ahb_req_type;

   typedef struct packed {
      logic tx_enable;
      logic rx_enable;
      logic mac_running;
      logic promiscuous_accept_bit;
      logic [47:0] station_addr;
      logic [15:0] max_frame_len;
      logic [15:0] pause_quanta;
      logic pause_allowed;
      logic [15:0] rx_sect_empty;
      logic [15:0] rx_sect_full;
   } emcr_cfg_type;

endpackage

// *** core/emcr_ahb_slave.sv ***
`timescale 1ns/100ps
`include "emcr_defs.svh"

module emcr_ahb_slave
   import emcr_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic arst_n, // async reset, active low
   input wire emcr_ahb_req_type req, // address phase signals
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // response
   output logic wr_en, // data-phase write strobe
   output logic rd_en, // address-phase read strobe
   output logic [3:0] rd_idx, // read index
   output logic [3:0] wr_idx, // write index
   output logic wr_hit // write index mapped
);

   logic wr_pend_q;
   logic [3:0] wr_idx_q;
   logic wr_ok_q;

   wire xfer = req.sel && hready && req.trans[1];
   wire word = req.size == `EMCR_HSIZE_WORD;
   wire [3:0] idx = req.addr[5:2];
   wire mapped = (req.addr[31:6] == 26'h0) && (idx <= `EMCR_IDX_LAST);

   // single-cycle answer: no wait states needed for flop storage
   assign hreadyout = 1'b1;
   assign hresp = `EMCR_HRESP_OKAY;
   assign rd_en = xfer && !req.write;
   // an unmapped address must not alias a low register on reads
   assign rd_idx = mapped ? idx : `EMCR_IDX_NONE;
   assign wr_en = wr_pend_q;
   assign wr_idx = wr_idx_q;
   assign wr_hit = wr_ok_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_pend_q <= 1'b0;
         wr_idx_q <= 4'h0;
         wr_ok_q <= 1'b0;
      end else begin
         wr_pend_q <= xfer && req.write && word;
         wr_idx_q <= idx;
         wr_ok_q <= mapped;
      end
   end

endmodule

// *** core/emcr_readmux.sv ***
`timescale 1ns/100ps
`include "emcr_defs.svh"

module emcr_readmux
   import emcr_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic arst_n, // async reset, active low
   input wire logic rd_en, // read strobe
   input wire logic [3:0] rd_idx, // read index
   input wire logic [31:0] version_word, // version word
   input wire logic [31:0] scratch_word, // scratch
   input wire logic [31:0] control_word, // control
   input wire emcr_cfg_type cfg, // live config
   output logic [31:0] hrdata // registered read data
);

   logic [31:0] hrdata_q;
   logic [31:0] sel_w;

   // unused upper bits read as zero
   always_comb begin
      sel_w = `EMCR_ZERO32;
      unique case (rd_idx)
         `EMCR_IDX_VERSION: sel_w = version_word;
         `EMCR_IDX_SCRATCH: sel_w = scratch_word;
         `EMCR_IDX_CONTROL: sel_w = control_word;
         `EMCR_IDX_ADDR_LO: sel_w = cfg.station_addr[31:0];
         `EMCR_IDX_ADDR_HI: sel_w = {`EMCR_ZERO16, cfg.station_addr[47:32]};
         `EMCR_IDX_FRM_LEN: sel_w = {`EMCR_ZERO16, cfg.max_frame_len};
         `EMCR_IDX_PAUSE: sel_w = {`EMCR_ZERO16, cfg.pause_quanta};
         `EMCR_IDX_SECT_EMP: sel_w = {`EMCR_ZERO16, cfg.rx_sect_empty};
         `EMCR_IDX_SECT_FUL: sel_w = {`EMCR_ZERO16, cfg.rx_sect_full};
         `EMCR_IDX_STATUS: sel_w = {30'h0, cfg.pause_allowed, cfg.mac_running};
         default: sel_w = `EMCR_ZERO32;
      endcase
   end

   assign hrdata = hrdata_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata_q <= `EMCR_ZERO32;
      end else if (rd_en) begin
         hrdata_q <= sel_w;
      end
   end

endmodule

// *** core/emcr_regs.sv ***
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`include "emcr_defs.svh"

module emcr_regs
   import emcr_pkg::*;
#(
   parameter logic [15:0] customer_revision_param = `EMCR_CUST_REV, // arbitrary
   parameter logic small_mac = 1'b0
)
(
   input wire logic clk, // system clock, 200 MHz
   input wire logic arst_n, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write flag
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // response, always okay
   output logic [31:0] hrdata, // read data
   input wire logic [15:0] rx_frame_len, // length of received frame
   input wire logic rx_frame_done, // frame length valid, one cycle
   input wire logic pause_req, // request to send a pause frame
   output logic rx_too_long, // received frame over the limit
   output logic pause_send, // pause frame strobe
   output logic [15:0] pause_quanta_out, // quanta for the pause frame
   output emcr_cfg_type cfg // live configuration
);

   emcr_ahb_req_type req;
   logic wr_en;
   logic rd_en;
   logic [3:0] rd_idx;
   logic [3:0] wr_idx;
   logic wr_hit;

   logic [31:0] scratch_q;
   logic [31:0] control_q;
   logic [31:0] addr_lo_q;
   logic [15:0] addr_hi_q;
   logic [15:0] frm_len_q;
   logic [15:0] pause_q;
   logic [15:0] sect_emp_q;
   logic [15:0] sect_ful_q;
   logic rx_too_long_q;
   logic pause_send_q;
   logic [15:0] pause_out_q;

   function automatic logic wsel(input logic [3:0] want,
                                 input logic [3:0] got,
                                 input logic en,
                                 input logic hit);
      wsel = en && hit && (got == want);
   endfunction

   assign req.addr = haddr;
   assign req.trans = htrans;
   assign req.write = hwrite;
   assign req.size = hsize;
   assign req.sel = hsel;

   emcr_ahb_slave u_bus (
      .clk(clk),
      .arst_n(arst_n),
      .req(req),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .wr_en(wr_en),
      .rd_en(rd_en),
      .rd_idx(rd_idx),
      .wr_idx(wr_idx),
      .wr_hit(wr_hit)
   );

   wire we_scratch = wsel(`EMCR_IDX_SCRATCH, wr_idx, wr_en, wr_hit);
   wire we_control = wsel(`EMCR_IDX_CONTROL, wr_idx, wr_en, wr_hit);
   wire we_addr_lo = wsel(`EMCR_IDX_ADDR_LO, wr_idx, wr_en, wr_hit);
   wire we_addr_hi = wsel(`EMCR_IDX_ADDR_HI, wr_idx, wr_en, wr_hit);
   wire we_frm_len = wsel(`EMCR_IDX_FRM_LEN, wr_idx, wr_en, wr_hit);
   wire we_pause = wsel(`EMCR_IDX_PAUSE, wr_idx, wr_en, wr_hit);
   wire we_sect_emp = wsel(`EMCR_IDX_SECT_EMP, wr_idx, wr_en, wr_hit);
   wire we_sect_ful = wsel(`EMCR_IDX_SECT_FUL, wr_idx, wr_en, wr_hit);
   wire we_srst = wsel(`EMCR_IDX_SOFT_RST, wr_idx, wr_en, wr_hit);
   wire soft_reset = we_srst && hwdata[`EMCR_SRST_BIT];

   // software reset wins over a control write in the same cycle
   wire [31:0] enable_mask = 32'h0000_0003;
   wire [31:0] control_d = soft_reset ? (control_q & ~enable_mask)
                         : we_control ? hwdata : control_q;

   // fixed values in the small variants; writes dropped there
   wire [15:0] sect_fixed = 16'(`EMCR_FIFO_DEPTH - `EMCR_SECT_MARGIN);
   wire [15:0] frm_len_w = small_mac ? `EMCR_FRM_LEN_RST : frm_len_q;
   wire [15:0] sect_emp_w = small_mac ? sect_fixed : sect_emp_q;

   wire [31:0] version_word = {customer_revision_param,
                               `EMCR_CORE_VERSION};

   assign cfg.tx_enable = control_q[`EMCR_TRANSMIT_ENABLE_BIT_BIT];
   assign cfg.rx_enable = control_q[`EMCR_RECEIVE_ENABLE_BIT_BIT];
   assign cfg.mac_running = cfg.tx_enable && cfg.rx_enable;
   assign cfg.promiscuous_accept_bit = control_q[`EMCR_PROMIS_BIT];
   assign cfg.station_addr = {addr_hi_q, addr_lo_q};
   assign cfg.max_frame_len = frm_len_w;
   assign cfg.pause_quanta = pause_q;
   assign cfg.pause_allowed = !small_mac;
   assign cfg.rx_sect_empty = sect_emp_w;
   assign cfg.rx_sect_full = sect_ful_q;

   emcr_readmux u_rd (
      .clk(clk),
      .arst_n(arst_n),
      .rd_en(rd_en),
      .rd_idx(rd_idx),
      .version_word(version_word),
      .scratch_word(scratch_q),
      .control_word(control_q),
      .cfg(cfg),
      .hrdata(hrdata)
   );

   wire too_long = rx_frame_done && (rx_frame_len > frm_len_w);
   wire pause_go = pause_req && cfg.mac_running && cfg.pause_allowed;

   assign rx_too_long = rx_too_long_q;
   assign pause_send = pause_send_q;
   assign pause_quanta_out = pause_out_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         scratch_q <= `EMCR_ZERO32;
         control_q <= `EMCR_ZERO32;
      end else begin
         if (we_scratch) begin
            scratch_q <= hwdata;
         end
         control_q <= control_d;
      end
   end

   // station address: byte 0 of the address sits in bits 7:0
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_lo_q <= `EMCR_ZERO32;
         addr_hi_q <= `EMCR_ZERO16;
      end else begin
         if (we_addr_lo) begin
            addr_lo_q <= hwdata;
         end
         if (we_addr_hi) begin
            addr_hi_q <= hwdata[15:0];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         frm_len_q <= `EMCR_FRM_LEN_RST;
         pause_q <= `EMCR_ZERO16;
      end else begin
         if (we_frm_len && !small_mac) begin
            frm_len_q <= hwdata[15:0];
         end
         if (we_pause) begin
            pause_q <= hwdata[15:0];
         end
      end
   end

   // thresholds are only stored; checking their order is left to software
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sect_emp_q <= `EMCR_ZERO16;
         sect_ful_q <= `EMCR_ZERO16;
      end else begin
         if (we_sect_emp && !small_mac) begin
            sect_emp_q <= hwdata[15:0];
         end
         if (we_sect_ful) begin
            sect_ful_q <= hwdata[15:0];
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_too_long_q <= 1'b0;
         pause_send_q <= 1'b0;
         pause_out_q <= `EMCR_ZERO16;
      end else begin
         rx_too_long_q <= too_long;
         pause_send_q <= pause_go;
         if (pause_go) begin
            pause_out_q <= pause_q;
         end
      end
   end

endmodule

// *** tb/emcr_regs_checker.sv ***
`timescale 1ns/100ps
module emcr_regs_checker
   import emcr_pkg::*;
(
   input wire logic clk, // clock
   input wire logic arst_n, // async reset
   input wire logic [15:0] rx_frame_len, // frame length
   input wire logic rx_frame_done, // length valid
   input wire logic pause_req, // pause request
   input wire logic rx_too_long, // over limit
   input wire logic pause_send, // pause strobe
   input wire logic [15:0] pause_quanta_out, // quanta sent
   input wire emcr_cfg_type cfg // live config
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!arst_n);
   a_len_compare: assert property (rx_frame_done |=>
      rx_too_long == ($past(rx_frame_len) > $past(cfg.max_frame_len)))
      else $error("frame length flag wrong");
   a_len_quiet: assert property (!rx_frame_done |=> !rx_too_long)
      else $error("frame length flag without frame");
   a_mac_running: assert property (
      cfg.mac_running == (cfg.tx_enable && cfg.rx_enable))
      else $error("running state wrong");
   a_pause_value: assert property (
      pause_send |-> pause_quanta_out == $past(cfg.pause_quanta))
      else $error("pause quanta wrong");
   a_pause_cause: assert property (
      pause_send |-> $past(pause_req) && $past(cfg.mac_running))
      else $error("pause without cause");
   a_pause_idle: assert property (!pause_req |=> !pause_send)
      else $error("pause without request");
   a_reset_state: assert property ($rose(arst_n) |->
      cfg.max_frame_len == 16'h05ee && cfg.pause_quanta == 16'h0000
      && cfg.rx_sect_empty == 16'h0000 && !cfg.mac_running)
      else $error("reset values wrong");
   a_reset_addr: assert property ($rose(arst_n) |->
      cfg.rx_sect_full == 16'h0000 && cfg.station_addr == 48'h0)
      else $error("reset address wrong");
endmodule

bind emcr_regs emcr_regs_checker u_emcr_regs_checker (.clk(clk),
   .arst_n(arst_n), .rx_frame_len(rx_frame_len),
   .rx_frame_done(rx_frame_done), .pause_req(pause_req),
   .rx_too_long(rx_too_long), .pause_send(pause_send),
   .pause_quanta_out(pause_quanta_out), .cfg(cfg));

// *** tb/emcr_tb.sv ***
`timescale 1ns/100ps
`include "emcr_defs.svh"
module tb import emcr_pkg::*;;
   logic clk, hreadyout, hresp, rx_too_long, pause_send;
   logic arst_n = 0, hsel = 0, hwrite = 0, rx_frame_done = 0, pause_req = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q, w;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 0;
   logic [15:0] rx_frame_len = 0, pause_quanta_out, len;
   emcr_cfg_type cfg;
   int err_total = 0, checks = 0;

   emcr_regs u_emcr_regs (.clk(clk), .arst_n(arst_n), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_frame_len(rx_frame_len),
      .rx_frame_done(rx_frame_done), .pause_req(pause_req),
      .rx_too_long(rx_too_long), .pause_send(pause_send),
      .pause_quanta_out(pause_quanta_out), .cfg(cfg));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // the single slave's ready is the bus ready, so waits end on hreadyout
   task automatic bus(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= `EMCR_HTRANS_NONSEQ;
      hsize <= `EMCR_HSIZE_WORD;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      chk("response", 48'(`EMCR_HRESP_OKAY), hresp);
      r = hrdata;
      #1;
   endtask

   task automatic strobe(input logic [15:0] l, input logic p);
      @(posedge clk);
      rx_frame_done <= ~p;
      pause_req <= p;
      rx_frame_len <= l;
      @(posedge clk);
      rx_frame_done <= 1'b0;
      pause_req <= 1'b0;
      #1;
   endtask

   task automatic chk(input string n, input logic [47:0] e,
                      input logic [47:0] g);
      checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   function automatic logic [31:0] rst_val(input int i);
      if (i == 0) return {`EMCR_CUST_REV, `EMCR_CORE_VERSION};
      return (i == 5) ? {16'h0000, `EMCR_FRM_LEN_RST} : 32'h0000_0000;
   endfunction

   // upper halves from index 4 on are unused and must read zero
   function automatic logic [31:0] rd_mask(input int i);
      return (i < 4) ? 32'hffff_ffff : 32'h0000_ffff;
   endfunction

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      print_verdict();
   end

   initial begin
      void'($urandom(32'h5348));
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         bus(1'b0, i * 4, 32'h0000_0000, q);
         chk("reset value", rst_val(i), q);
      end
      $display("test reset done");
      for (int i = 0; i < 9; i++) begin
         w = $urandom();
         bus(1'b1, i * 4, w, q);
         bus(1'b0, i * 4, 32'h0000_0000, q);
         chk("readback", i ? w & rd_mask(i) : rst_val(0), q);
      end
      bus(1'b1, 32'h0000_0044, 32'hffff_ffff, q);
      bus(1'b0, 32'h0000_0044, 32'h0000_0000, q);
      chk("unmapped", 48'h0, q);
      bus(1'b1, 32'h0000_000c, 32'h1723_1c00, q);
      bus(1'b1, 32'h0000_0010, 32'h0000_cb4a, q);
      chk("station", 48'hcb4a_1723_1c00, cfg.station_addr);
      bus(1'b1, 32'h0000_0020, 32'h0000_0010, q);
      w = {16'h0000, 16'(`EMCR_FIFO_DEPTH - `EMCR_SECT_MARGIN)};
      bus(1'b1, 32'h0000_001c, w, q);
      bus(1'b0, 32'h0000_001c, 32'h0000_0000, q);
      chk("section empty", w, q);
      chk("section full", 48'h10, cfg.rx_sect_full);
      $display("test access done");
      len = 16'($urandom_range(16'hfff0, 16'h0100));
      bus(1'b1, 32'h0000_0014, {16'hffff, len}, q);
      for (int d = -1; d < 2; d++) begin
         strobe(16'(len + d), 1'b0);
         chk("too long", d > 0, rx_too_long);
      end
      $display("test length done");
      w = $urandom() | 32'h0000_0003;
      bus(1'b1, 32'h0000_0018, w, q);
      bus(1'b1, 32'h0000_0004, w, q);
      bus(1'b1, 32'h0000_0008, w, q);
      chk("running", 48'h1, cfg.mac_running);
      bus(1'b0, 32'h0000_0028, 32'h0000_0000, q);
      chk("status", 48'h3, q);
      strobe(16'h0000, 1'b1);
      chk("pause", {1'b1, w[15:0]}, {pause_send, pause_quanta_out});
      bus(1'b1, 32'h0000_0024, 32'h0000_0001, q);
      bus(1'b0, 32'h0000_0008, 32'h0000_0000, q);
      chk("control", w & 32'hffff_fffc, q);
      bus(1'b0, 32'h0000_0004, 32'h0000_0000, q);
      chk("scratch", w, q);
      strobe(16'h0000, 1'b1);
      chk("pause off", 48'h0, pause_send);
      bus(1'b0, 32'h0000_0028, 32'h0000_0000, q);
      chk("status off", 48'h2, q);
      $display("test soft reset done");
      print_verdict();
   end
endmodule
